// ### ctp_pkg.sv
// Constants, register map and reset values of the three-phase complementary PWM block
package ctp_pkg;

  // Timing of the reference set-up, in its own units
  localparam int unsigned PCLK_NS    = 100;      // 10 MHz bus clock
  localparam int unsigned CARRIER_NS = 400000;   // 400 us carrier, 2.5 kHz
  localparam int unsigned DEAD_NS    = 4000;     // 4 us non-overlap
  localparam int unsigned REF_DIV    = 4;        // Reference counter prescale
  localparam int unsigned TICK_NS    = PCLK_NS * REF_DIV;

  // Derived counts in counter ticks; dead time is a least time, rounds up
  localparam logic [15:0] RST_DEAD  = 16'((DEAD_NS + TICK_NS - 1) / TICK_NS);
  localparam logic [15:0] RST_HALF  = 16'((CARRIER_NS / 2) / TICK_NS);
  localparam logic [15:0] RST_UPPER = 16'(((CARRIER_NS / 2) / TICK_NS) + ((DEAD_NS + TICK_NS - 1) / TICK_NS));
  localparam logic [15:0] RST_DUTY  = 16'((((CARRIER_NS / 2) / TICK_NS) + ((DEAD_NS + TICK_NS - 1) / TICK_NS)) / 2);

  // Byte offsets of the registers
  localparam logic [7:0] OFS_CTRL        = 8'h00;
  localparam logic [7:0] OFS_UPPER_CMP   = 8'h04;
  localparam logic [7:0] OFS_P1_CMP      = 8'h08;
  localparam logic [7:0] OFS_UPPER_BUF   = 8'h0c;
  localparam logic [7:0] OFS_P1_BUF      = 8'h10;
  localparam logic [7:0] OFS_P2_CMP      = 8'h14;
  localparam logic [7:0] OFS_P3_CMP      = 8'h18;
  localparam logic [7:0] OFS_P2_BUF      = 8'h1c;
  localparam logic [7:0] OFS_P3_BUF      = 8'h20;
  localparam logic [7:0] OFS_LEAD_CNT    = 8'h24;
  localparam logic [7:0] OFS_LAG_CNT     = 8'h28;
  localparam logic [7:0] OFS_DEAD        = 8'h2c;
  localparam logic [7:0] OFS_HALF        = 8'h30;
  localparam logic [7:0] OFS_HALF_BUF    = 8'h34;
  localparam logic [7:0] OFS_STATUS      = 8'h38;

  // Control register fields
  localparam int unsigned CTRL_W          = 9;
  localparam int unsigned CTRL_RUN_BIT    = 0;
  localparam int unsigned CTRL_NODEAD_BIT = 1;
  localparam int unsigned CTRL_TOG_BIT    = 2;
  localparam int unsigned CTRL_NEG_LVL    = 3;
  localparam int unsigned CTRL_POS_LVL    = 4;
  localparam int unsigned CTRL_PRE_LSB    = 5;
  localparam int unsigned CTRL_MODE_LSB   = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST  = 9'h1a4;  // Toggle on, divide by 4, mode 3

  // Transfer mode bits: crest, trough; both set is mode 3
  localparam int unsigned MODE_CREST_BIT  = 0;
  localparam int unsigned MODE_TROUGH_BIT = 1;

  // Prescaler selections
  localparam logic [1:0] PRE_DIV1  = 2'h0;
  localparam logic [1:0] PRE_DIV4  = 2'h1;
  localparam logic [1:0] PRE_DIV16 = 2'h2;
  localparam logic [5:0] PRE_LIM1  = 6'h00;
  localparam logic [5:0] PRE_LIM4  = 6'h03;
  localparam logic [5:0] PRE_LIM16 = 6'h0f;
  localparam logic [5:0] PRE_LIM64 = 6'h3f;

endpackage

// ### ctp_pwm.sv
// Three-phase complementary PWM generator with APB register access
`timescale 1ns/1ps

module ctp_pwm (
  input  wire logic        pclk,                 // Bus and counter clock
  input  wire logic        presetn,              // Async reset, active low
  input  wire logic        psel,                 // APB select
  input  wire logic        penable,              // APB enable
  input  wire logic        pwrite,               // APB write
  input  wire logic [7:0]  paddr,                // APB byte address
  input  wire logic [31:0] pwdata,               // APB write data
  output logic      [31:0] prdata,               // APB read data
  output logic             pready,               // APB ready
  output logic             pslverr,              // APB error, unmapped address
  output logic             carrier_toggle_out,   // Toggles once per carrier
  output logic             phase1_positive_out,  // Phase 1 positive pin
  output logic             phase1_inverse_out,   // Phase 1 inverse pin
  output logic             phase2_positive_out,  // Phase 2 positive pin
  output logic             phase2_inverse_out,   // Phase 2 inverse pin
  output logic             phase3_positive_out,  // Phase 3 positive pin
  output logic             phase3_inverse_out,   // Phase 3 inverse pin
  output logic             compare_req           // One-cycle pulse at crest
);
  import ctp_pkg::*;

  logic [CTRL_W-1:0] ctrl_q;
  logic [15:0]       upper_cmp_q;
  logic [15:0]       upper_buf_q;
  logic [15:0]       upper_stage_q;
  logic [15:0]       half_q;
  logic [15:0]       half_buf_q;
  logic [15:0]       half_stage_q;
  logic [15:0]       dead_q;
  logic [15:0]       duty_cmp_q   [3];
  logic [15:0]       duty_buf_q   [3];
  logic [15:0]       duty_stage_q [3];
  logic [15:0]       lead_q;
  logic [15:0]       lag_q;
  logic              lead_dn_q;
  logic              lag_dn_q;
  logic              started_q;
  logic              pend_q;
  logic [5:0]        pre_cnt_q;
  logic [5:0]        pre_lim;
  logic              pready_q;
  logic              pslverr_q;
  logic [31:0]       prdata_q;
  logic [31:0]       rd_data;
  logic              rd_err;
  logic              car_q;
  logic              req_q;
  logic [2:0]        pos_out_q;
  logic [2:0]        inv_out_q;
  logic [2:0]        pos_on_q;
  logic [2:0]        inv_on_q;
  logic              run;
  logic              tick;
  logic              crest_evt;
  logic              trough_evt;
  logic              xfer;
  logic              wr_en;
  logic              arm;
  logic [1:0]        mode;

  assign run   = ctrl_q[CTRL_RUN_BIT];
  assign mode  = ctrl_q[CTRL_MODE_LSB +: 2];
  assign wr_en = psel && penable && pready_q && pwrite;
  assign arm   = wr_en && (paddr == OFS_P3_BUF);

  // Bus answers come from flops, one wait-free access phase
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // Read decode; staging registers deliberately absent
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    if (paddr == OFS_CTRL) begin
      rd_data = {23'h000000, ctrl_q};
    end else if (paddr == OFS_UPPER_CMP) begin
      rd_data = {16'h0000, upper_cmp_q};
    end else if (paddr == OFS_P1_CMP) begin
      rd_data = {16'h0000, duty_cmp_q[0]};
    end else if (paddr == OFS_UPPER_BUF) begin
      rd_data = {16'h0000, upper_buf_q};
    end else if (paddr == OFS_P1_BUF) begin
      rd_data = {16'h0000, duty_buf_q[0]};
    end else if (paddr == OFS_P2_CMP) begin
      rd_data = {16'h0000, duty_cmp_q[1]};
    end else if (paddr == OFS_P3_CMP) begin
      rd_data = {16'h0000, duty_cmp_q[2]};
    end else if (paddr == OFS_P2_BUF) begin
      rd_data = {16'h0000, duty_buf_q[1]};
    end else if (paddr == OFS_P3_BUF) begin
      rd_data = {16'h0000, duty_buf_q[2]};
    end else if (paddr == OFS_LEAD_CNT) begin
      rd_data = {16'h0000, lead_q};
    end else if (paddr == OFS_LAG_CNT) begin
      rd_data = {16'h0000, lag_q};
    end else if (paddr == OFS_DEAD) begin
      rd_data = {16'h0000, dead_q};
    end else if (paddr == OFS_HALF) begin
      rd_data = {16'h0000, half_q};
    end else if (paddr == OFS_HALF_BUF) begin
      rd_data = {16'h0000, half_buf_q};
    end else if (paddr == OFS_STATUS) begin
      rd_data = {28'h0000000, started_q, pend_q, lag_dn_q, lead_dn_q};
    end else begin
      rd_err = 1'b1;
    end
  end

  // APB answer captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q <= psel && !penable;
      if (psel && !penable) begin
        pslverr_q <= rd_err;
        prdata_q  <= pwrite ? 32'h0000_0000 : rd_data;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // Control and dead-time registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      dead_q <= RST_DEAD;
    end else if (wr_en && paddr == OFS_CTRL) begin
      ctrl_q <= pwdata[CTRL_W-1:0];
    end else if (wr_en && paddr == OFS_DEAD) begin
      dead_q <= pwdata[15:0];
    end
  end

  // Prescaler selection
  always_comb begin
    case (ctrl_q[CTRL_PRE_LSB +: 2])
      PRE_DIV1:  pre_lim = PRE_LIM1;
      PRE_DIV4:  pre_lim = PRE_LIM4;
      PRE_DIV16: pre_lim = PRE_LIM16;
      default:   pre_lim = PRE_LIM64;
    endcase
  end

  assign tick = started_q && (pre_cnt_q == pre_lim);

  // Prescaler restarts with the counters so both phases stay aligned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_q <= 6'h00;
    end else if (!run || !started_q || tick) begin
      pre_cnt_q <= 6'h00;
    end else begin
      pre_cnt_q <= pre_cnt_q + 6'h01;
    end
  end

  assign crest_evt  = tick && !lead_dn_q && (lead_q == upper_cmp_q);
  assign trough_evt = tick && lag_dn_q && (lag_q == 16'h0000);
  assign xfer       = pend_q && ((crest_evt && mode[MODE_CREST_BIT]) ||
                                 (trough_evt && mode[MODE_TROUGH_BIT]));

  // Lead and lag counters; lead stays dead-time ahead of lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      started_q <= 1'b0;
      lead_q    <= 16'h0000;
      lag_q     <= 16'h0000;
      lead_dn_q <= 1'b0;
      lag_dn_q  <= 1'b0;
    end else if (!run) begin
      started_q <= 1'b0;
      if (wr_en && paddr == OFS_LEAD_CNT) begin
        lead_q <= pwdata[15:0];
      end else if (wr_en && paddr == OFS_LAG_CNT) begin
        lag_q <= pwdata[15:0];
      end
    end else if (!started_q) begin
      started_q <= 1'b1;
      lead_q    <= dead_q;
      lag_q     <= 16'h0000;
      lead_dn_q <= 1'b0;
      lag_dn_q  <= 1'b0;
    end else if (tick) begin
      if (!lead_dn_q && lead_q == upper_cmp_q) begin
        lead_dn_q <= 1'b1;
        lead_q    <= lead_q - 16'h0001;
      end else if (lead_dn_q && lead_q == dead_q) begin
        lead_dn_q <= 1'b0;
        lead_q    <= lead_q + 16'h0001;
      end else begin
        lead_q <= lead_dn_q ? lead_q - 16'h0001 : lead_q + 16'h0001;
      end
      if (!lag_dn_q && lag_q == half_q) begin
        lag_dn_q <= 1'b1;
        lag_q    <= lag_q - 16'h0001;
      end else if (lag_dn_q && lag_q == 16'h0000) begin
        lag_dn_q <= 1'b0;
        lag_q    <= lag_q + 16'h0001;
      end else begin
        lag_q <= lag_dn_q ? lag_q - 16'h0001 : lag_q + 16'h0001;
      end
    end
  end

  // Transfer armed by the last buffer write; arming beats a clearing transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
    end else if (arm) begin
      pend_q <= 1'b1;
    end else if (xfer) begin
      pend_q <= 1'b0;
    end
  end

  // Buffer registers are always writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_buf_q   <= RST_UPPER;
      half_buf_q    <= RST_HALF;
      duty_buf_q[0] <= RST_DUTY;
      duty_buf_q[1] <= RST_DUTY;
      duty_buf_q[2] <= RST_DUTY;
    end else if (wr_en) begin
      if (paddr == OFS_UPPER_BUF) begin
        upper_buf_q <= pwdata[15:0];
      end else if (paddr == OFS_HALF_BUF) begin
        half_buf_q <= pwdata[15:0];
      end else if (paddr == OFS_P1_BUF) begin
        duty_buf_q[0] <= pwdata[15:0];
      end else if (paddr == OFS_P2_BUF) begin
        duty_buf_q[1] <= pwdata[15:0];
      end else if (paddr == OFS_P3_BUF) begin
        duty_buf_q[2] <= pwdata[15:0];
      end
    end
  end

  // Staging snapshot; phase-three word taken from the bus as it lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_stage_q   <= RST_UPPER;
      half_stage_q    <= RST_HALF;
      duty_stage_q[0] <= RST_DUTY;
      duty_stage_q[1] <= RST_DUTY;
      duty_stage_q[2] <= RST_DUTY;
    end else if (arm) begin
      upper_stage_q   <= upper_buf_q;
      half_stage_q    <= half_buf_q;
      duty_stage_q[0] <= duty_buf_q[0];
      duty_stage_q[1] <= duty_buf_q[1];
      duty_stage_q[2] <= pwdata[15:0];
    end
  end

  // Active compares: staging at transfer points, direct writes only when stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_cmp_q   <= RST_UPPER;
      half_q        <= RST_HALF;
      duty_cmp_q[0] <= RST_DUTY;
      duty_cmp_q[1] <= RST_DUTY;
      duty_cmp_q[2] <= RST_DUTY;
    end else if (xfer) begin
      upper_cmp_q   <= upper_stage_q;
      half_q        <= half_stage_q;
      duty_cmp_q[0] <= duty_stage_q[0];
      duty_cmp_q[1] <= duty_stage_q[1];
      duty_cmp_q[2] <= duty_stage_q[2];
    end else if (wr_en && !run) begin
      if (paddr == OFS_UPPER_CMP) begin
        upper_cmp_q <= pwdata[15:0];
      end else if (paddr == OFS_HALF) begin
        half_q <= pwdata[15:0];
      end else if (paddr == OFS_P1_CMP) begin
        duty_cmp_q[0] <= pwdata[15:0];
      end else if (paddr == OFS_P2_CMP) begin
        duty_cmp_q[1] <= pwdata[15:0];
      end else if (paddr == OFS_P3_CMP) begin
        duty_cmp_q[2] <= pwdata[15:0];
      end
    end
  end

  // Carrier toggle output and compare request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      car_q <= 1'b1;
      req_q <= 1'b0;
    end else begin
      req_q <= crest_evt;
      if (!ctrl_q[CTRL_TOG_BIT]) begin
        car_q <= 1'b1;
      end else if (crest_evt) begin
        car_q <= ~car_q;
      end
    end
  end

  assign carrier_toggle_out = car_q;
  assign compare_req        = req_q;

  // One pair per duty compare; the gap is where lag sits within dead of duty
  for (genvar i = 0; i < 3; i++) begin : g_phase
    logic [16:0] lag_plus_dead;
    logic        pos_on;
    logic        inv_on;
    assign lag_plus_dead = {1'b0, lag_q} + {1'b0, dead_q};
    assign pos_on = started_q && (duty_cmp_q[i] < upper_cmp_q) && (lag_q >= duty_cmp_q[i]);
    assign inv_on = started_q && (ctrl_q[CTRL_NODEAD_BIT] ? !pos_on :
                    ((duty_cmp_q[i] >= upper_cmp_q) || (lag_plus_dead < {1'b0, duty_cmp_q[i]})));

    // Level select maps on/off onto the pin; select 0 means active low
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pos_on_q[i]  <= 1'b0;
        inv_on_q[i]  <= 1'b0;
        pos_out_q[i] <= 1'b1;
        inv_out_q[i] <= 1'b1;
      end else begin
        pos_on_q[i]  <= pos_on;
        inv_on_q[i]  <= inv_on;
        pos_out_q[i] <= ~(pos_on ^ ctrl_q[CTRL_POS_LVL]);
        inv_out_q[i] <= ~(inv_on ^ ctrl_q[CTRL_NEG_LVL]);
      end
    end

    pair_overlap_a: assert property (@(posedge pclk) disable iff (!presetn)
      !(pos_on_q[i] && inv_on_q[i]))
      else $error("positive and inverse both active");

    staging_path_a: assert property (@(posedge pclk) disable iff (!presetn)
      (run && $past(run) && duty_cmp_q[i] != $past(duty_cmp_q[i])) |-> $past(xfer))
      else $error("duty compare changed without staged transfer");

    zero_duty_a: assert property (@(posedge pclk) disable iff (!presetn)
      (started_q && duty_cmp_q[i] == 16'h0000) ##1 (duty_cmp_q[i] == 16'h0000) |-> pos_on_q[i] && !inv_on_q[i])
      else $error("zero duty does not hold positive on");
  end

  assign phase1_positive_out = pos_out_q[0];
  assign phase1_inverse_out  = inv_out_q[0];
  assign phase2_positive_out = pos_out_q[1];
  assign phase2_inverse_out  = inv_out_q[1];
  assign phase3_positive_out = pos_out_q[2];
  assign phase3_inverse_out  = inv_out_q[2];

  carrier_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (crest_evt && ctrl_q[CTRL_TOG_BIT]) |=> (car_q != $past(car_q)))
    else $error("carrier output did not toggle at crest");

  lead_reverse_a: assert property (@(posedge pclk) disable iff (!presetn)
    (crest_evt && run) |=> lead_dn_q && (lead_q == $past(lead_q) - 16'h0001))
    else $error("lead counter did not turn down at upper limit");

  lag_reverse_a: assert property (@(posedge pclk) disable iff (!presetn)
    (run && trough_evt) |=> !lag_dn_q && (lag_q == 16'h0001))
    else $error("lag counter did not turn up at zero");

  counter_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    (run && !started_q) |=> (lead_q == $past(dead_q)) && (lag_q == 16'h0000) && started_q)
    else $error("counters did not start from dead time and zero");

  crest_request_a: assert property (@(posedge pclk) disable iff (!presetn)
    crest_evt |=> compare_req ##1 !compare_req)
    else $error("compare request not a single pulse at crest");

  both_transfer_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pend_q && !arm && mode == 2'h3 && (crest_evt || trough_evt)) |=>
      (upper_cmp_q == $past(upper_stage_q)) && !pend_q)
    else $error("mode 3 transfer missed at crest or trough");

  half_locked_a: assert property (@(posedge pclk) disable iff (!presetn)
    (run && !xfer && wr_en && paddr == OFS_HALF) |=> (half_q == $past(half_q)))
    else $error("half cycle written directly while running");

endmodule

// ### ctp_gate_model.sv
// Gate driver model: watches the three pin pairs and counts overlapping on-times
`timescale 1ns/1ps
module ctp_gate_model (
  input  wire logic       pclk,      // Sampling clock
  input  wire logic       presetn,   // Reset, active low
  input  wire logic [2:0] pos_pin,   // Positive pins, phases 1 to 3
  input  wire logic [2:0] neg_pin,   // Inverse pins, phases 1 to 3
  output int              overlap_n  // Cycles with a pair both on
);
  // Drivers are wired for active-low inputs on both switches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overlap_n <= 0;
    end else if ((~pos_pin & ~neg_pin) != 3'h0) begin
      overlap_n <= overlap_n + 1;
    end
  end
endmodule

// ### tb.sv
// Self-checking bench of the three-phase PWM block
`timescale 1ns/1ps
module tb;
  import ctp_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        car;
  logic        cmp_req;
  logic [2:0]  pos;
  logic [2:0]  neg;
  int          ovl;
  int          cnt[5];
  int          n_mismatch;
  int          comparisons;

  ctp_pwm dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .carrier_toggle_out(car), .phase1_positive_out(pos[0]), .phase1_inverse_out(neg[0]),
    .phase2_positive_out(pos[1]), .phase2_inverse_out(neg[1]), .phase3_positive_out(pos[2]),
    .phase3_inverse_out(neg[2]), .compare_req(cmp_req));
  ctp_gate_model drv (.pclk(pclk), .presetn(presetn), .pos_pin(pos), .neg_pin(neg), .overlap_n(ovl));

  // 10 MHz bus clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits on pready as long as it takes, the watchdog ends a dead slave
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk_val({r[31:1], r[0] | e}, exp);
  endtask

  // Pulses, carrier toggles, phase-2 gap cycles, fixed-phase faults, phase-2 equal pins
  task automatic run_count(input int n);
    logic last;
    cnt = '{0, 0, 0, 0, 0};
    last = car;
    repeat (n) begin
      @(posedge pclk);
      cnt[0] += int'(cmp_req === 1'b1);
      cnt[1] += int'(car !== last);
      last = car;
      cnt[2] += int'(pos[1] === 1'b1 && neg[1] === 1'b1);
      cnt[3] += int'(pos[0] !== 1'b0 || neg[0] !== 1'b1 || pos[2] !== 1'b1 || neg[2] !== 1'b0);
      cnt[4] += int'(pos[1] === neg[1]);
    end
  endtask

  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    chk_val({28'h0, car, pos}, 32'hf);
    rd_chk(OFS_CTRL, 32'(CTRL_RST));
    rd_chk(OFS_UPPER_CMP, 32'(RST_UPPER));
    rd_chk(OFS_HALF, 32'(RST_HALF));
    rd_chk(OFS_P3_BUF, 32'(RST_DUTY));
    rd_chk(OFS_LAG_CNT, 32'h0);
    wr(OFS_DEAD, 32'hffff_abcd);
    rd_chk(OFS_DEAD, 32'h0000_abcd);
    apb(1'b0, 8'h3c, 32'h0, r, e);
    chk_val({r[31:1], e}, 32'h1);
  endtask

  // Small carrier: dead 2, half 20, upper 22; duties 0, 10 and 22 at /1
  task automatic t_run();
    logic [7:0]  a[11] = '{OFS_DEAD, OFS_UPPER_CMP, OFS_HALF, OFS_UPPER_BUF, OFS_HALF_BUF, OFS_P1_CMP,
                           OFS_P2_CMP, OFS_P3_CMP, OFS_P1_BUF, OFS_P2_BUF, OFS_P3_BUF};
    logic [15:0] v[11] = '{16'h2, 16'h16, 16'h14, 16'h16, 16'h14, 16'h0, 16'ha, 16'h16, 16'h0, 16'ha, 16'h16};
    for (int i = 0; i < 11; i++) begin
      wr(a[i], {16'h0, v[i]});
    end
    wr(OFS_CTRL, 32'h185);
    repeat (4) @(posedge pclk);
    run_count(400);
    chk_val(cnt[0], 32'd10);
    chk_val(cnt[1], 32'd10);
    chk_val(cnt[2], 32'd40);
    chk_val(cnt[3], 32'd0);
  endtask

  task automatic t_transfer();
    wr(OFS_P1_CMP, 32'h7);
    rd_chk(OFS_P1_CMP, 32'h0);
    wr(OFS_HALF, 32'h1e);
    rd_chk(OFS_HALF, 32'h14);
    wr(OFS_P1_BUF, 32'h5);
    wr(OFS_P3_BUF, 32'h17);
    // Crest or trough comes within half a carrier in mode 3
    repeat (22) @(posedge pclk);
    rd_chk(OFS_P1_CMP, 32'h5);
    rd_chk(OFS_P3_CMP, 32'h17);
  endtask

  task automatic t_nodead();
    wr(OFS_CTRL, 32'h187);
    repeat (2) @(posedge pclk);
    run_count(200);
    chk_val(cnt[4], 32'd0);
  endtask

  task automatic t_prescale();
    logic [31:0] ld;
    logic [31:0] lg;
    logic        e;
    wr(OFS_CTRL, 32'h184);
    apb(1'b0, OFS_LEAD_CNT, 32'h0, ld, e);
    apb(1'b0, OFS_LAG_CNT, 32'h0, lg, e);
    chk_val(ld, lg + 32'h2);
    wr(OFS_CTRL, 32'h1a5);
    repeat (4) @(posedge pclk);
    run_count(640);
    chk_val(cnt[0], 32'd4);
    chk_val(ovl, 32'd0);
  endtask

  // Positive side active high, carrier toggle off
  task automatic t_polarity();
    wr(OFS_CTRL, 32'h1b1);
    repeat (4) @(posedge pclk);
    run_count(200);
    chk_val(cnt[1], 32'd0);
    chk_val({29'h0, car, pos[2], neg[2]}, 32'h4);
  endtask

  // Divide by 16, trough-only transfer: crest passes first, the staged duty lands at the trough
  task automatic t_modes();
    wr(OFS_CTRL, 32'h184);
    wr(OFS_P1_BUF, 32'h3);
    wr(OFS_P3_BUF, 32'h17);
    wr(OFS_CTRL, 32'h145);
    run_count(400);
    chk_val(cnt[0], 32'd1);
    rd_chk(OFS_P1_CMP, 32'h5);
    repeat (300) @(posedge pclk);
    rd_chk(OFS_P1_CMP, 32'h3);
  endtask

  task automatic final_report();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    n_mismatch = 0;
    comparisons = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_run();
    t_transfer();
    t_nodead();
    t_prescale();
    t_polarity();
    t_modes();
    final_report();
  end

  // Watchdog well beyond the few thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    final_report();
  end
endmodule
